// *** bench/rdc_host_model.sv ***
`timescale 1ns/100ps
module rdc_host_model (
    input wire logic sda_oe_i,
    output wire logic scl_o,
    output wire logic sda_o
);
    // ==========
    // Bus host; the clock rests high between frames.
    localparam time Q = 75;
    logic scl_q = 1'b1;
    logic low_q = 1'b0;
    assign scl_o = scl_q;
    assign sda_o = !(low_q || sda_oe_i);

    task automatic start();
        low_q = 1'b0;
        #Q;
        scl_q = 1'b1;
        #(2 * Q);
        low_q = 1'b1;
        #(2 * Q);
        scl_q = 1'b0;
        #Q;
    endtask : start

    task automatic stop();
        low_q = 1'b1;
        #Q;
        scl_q = 1'b1;
        #(2 * Q);
        low_q = 1'b0;
        #(2 * Q);
    endtask : stop

    task automatic bit_io(input logic b, output logic r);
        low_q = !b;
        #Q;
        scl_q = 1'b1;
        #Q;
        r = sda_o;
        #Q;
        scl_q = 1'b0;
        #Q;
    endtask : bit_io

    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ack_in, ack);
    endtask : xfer
endmodule : rdc_host_model

// *** bench/rdc_monitor.sv ***
`timescale 1ns/100ps
module rdc_monitor (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic reg_reset_n_i,
    input wire logic cable_absent_n_i,
    input wire rdc_pkg::rdc_lvl_t config_source_select_i,
    input wire logic detect_level_pin_i,
    input wire logic [7:0] activity_i,
    input wire logic eeprom_load_ok_i,
    input wire rdc_pkg::rdc_ch_cfg_t [7:0] ch_cfg_o,
    input wire logic [1:0] detect_level_o,
    input wire logic low_power_o,
    input wire logic [7:0] in_term_50_o,
    input wire logic [7:0] out_term_50_o,
    input wire logic det_probe_o,
    input wire logic [7:0] squelch_o,
    input wire logic load_status_o
);
    // ==========
    // Port checks.
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);

    cable_power_a: assert property ($rose(cable_absent_n_i) |-> ##[1:4] low_power_o)
        else $error("low power late");
    restart_terms_a: assert property ($fell(cable_absent_n_i) |->
        ##4 (!low_power_o && out_term_50_o == 8'h00 && in_term_50_o == 8'h00))
        else $error("terms after return");
    absent_terms_a: assert property (low_power_o [*3] |-> (out_term_50_o | in_term_50_o) == 8'h00)
        else $error("terms in low power");
    probe_stop_a: assert property ($rose(low_power_o) |-> ##2 !det_probe_o)
        else $error("probe in low power");
    squelch_idle_a: assert property ($stable(activity_i) [*4] |-> (squelch_o ^ activity_i) == 8'hff)
        else $error("squelch wrong");
    load_fail_a: assert property (!eeprom_load_ok_i [*5] |-> !$rose(load_status_o))
        else $error("load status rose");
    reg_default_a: assert property (
        (!reg_reset_n_i && config_source_select_i == rdc_pkg::RDC_LVL_HIGH) [*6] |-> ch_cfg_o == '0)
        else $error("config not default");
    pin_level_a: assert property (
        (config_source_select_i == rdc_pkg::RDC_LVL_LOW && !detect_level_pin_i) [*6] |-> detect_level_o == 2'h0)
        else $error("pin threshold");
    sda_hold_a: assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_o))
        else $error("data moved in high");
endmodule : rdc_monitor

bind rdc_top rdc_monitor i_rdc_monitor (
    .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o), .reg_reset_n_i(reg_reset_n_i),
    .cable_absent_n_i(cable_absent_n_i), .config_source_select_i(config_source_select_i),
    .detect_level_pin_i(detect_level_pin_i), .activity_i(activity_i), .eeprom_load_ok_i(eeprom_load_ok_i),
    .ch_cfg_o(ch_cfg_o), .detect_level_o(detect_level_o), .low_power_o(low_power_o),
    .in_term_50_o(in_term_50_o), .out_term_50_o(out_term_50_o), .det_probe_o(det_probe_o),
    .squelch_o(squelch_o), .load_status_o(load_status_o)
);

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    // ==========
    // Pins, clock and the design.
    localparam logic [3:0] STRAP = 4'h5;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic rst_n = 1'b1;
    logic absent_n = 1'b0;
    rdc_pkg::rdc_lvl_t src = rdc_pkg::RDC_LVL_HIGH;
    rdc_pkg::rdc_eq_pins_t eq_a = '0;
    rdc_pkg::rdc_eq_pins_t eq_b = '0;
    logic [1:0] gain_a = 2'h0;
    logic [1:0] gain_b = 2'h0;
    logic swing = 1'b0;
    logic lvl_pin = 1'b0;
    logic [7:0] activity = 8'h00;
    logic [7:0] far_end = 8'h00;
    logic done = 1'b0;
    logic ok = 1'b0;
    logic scl, sda, sda_oe, low_power, probe, load_status;
    logic [1:0] level;
    logic [7:0] in_term, out_term, squelch;
    rdc_pkg::rdc_ch_cfg_t [7:0] cfg;
    int miscompares = 0;
    int tests_run = 0;

    always #5 clk_i = ~clk_i;

    rdc_top #(.DET_WINDOW_CYC(20)) i_rdc_top (
        .clk_i(clk_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
        .addr_strap_i(STRAP), .reg_reset_n_i(rst_n), .cable_absent_n_i(absent_n),
        .config_source_select_i(src), .bank_a_eq_pins_i(eq_a), .bank_b_eq_pins_i(eq_b),
        .bank_a_gain_pins_i(gain_a), .bank_b_gain_pins_i(gain_b), .swing_select_i(swing),
        .detect_level_pin_i(lvl_pin), .activity_i(activity), .far_end_detect_i(far_end),
        .eeprom_load_done_i(done), .eeprom_load_ok_i(ok), .ch_cfg_o(cfg), .detect_level_o(level),
        .low_power_o(low_power), .in_term_50_o(in_term), .out_term_50_o(out_term),
        .det_probe_o(probe), .squelch_o(squelch), .load_status_o(load_status)
    );
    rdc_host_model i_host (.sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

    // ==========
    // Shared tasks.
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic clks(input int n);
        repeat (n) @(posedge clk_i);
    endtask : clks

    task automatic send(input logic [7:0] b, input logic nack);
        logic [7:0] rx;
        logic ack;
        i_host.xfer(b, 1'b1, rx, ack);
        check("byte ack", 8'(nack), 8'(ack));
    endtask : send

    task automatic reg_write(input logic [7:0] ptr, input logic [7:0] data);
        i_host.start();
        send({3'h7, STRAP, 1'b0}, 1'b0);
        send(ptr, 1'b0);
        send(data, 1'b0);
        i_host.stop();
    endtask : reg_write

    task automatic reg_read(input logic [7:0] ptr, input logic [7:0] exp, input string what);
        logic [7:0] rx;
        logic ack;
        i_host.start();
        send({3'h7, STRAP, 1'b0}, 1'b0);
        send(ptr, 1'b0);
        i_host.start();
        send({3'h7, STRAP, 1'b1}, 1'b0);
        i_host.xfer(8'hff, 1'b1, rx, ack);
        i_host.stop();
        check(what, exp, rx);
    endtask : reg_read

    function automatic logic [7:0] pd_bits();
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v[i ^ 4] = cfg[i].power_down;
        end
        return v;
    endfunction : pd_bits

    // ==========
    // Scenarios.
    task automatic t_reset();
        check("low power", 8'h00, 8'(low_power));
        reg_read(8'h02, 8'h00, "power down reset");
        reg_read(8'h03, 8'h00, "config reset");
    endtask : t_reset

    task automatic t_power_down();
        reg_write(8'h02, 8'ha5);
        clks(2);
        check("power down out", 8'ha5, pd_bits());
        reg_read(8'h02, 8'ha5, "power down read");
        reg_write(8'h01, 8'hff);
        reg_read(8'h01, 8'h00, "status write ignored");
    endtask : t_power_down

    task automatic t_config();
        reg_write(8'h03, 8'hff);
        reg_write(8'h0a, 8'h96);
        clks(2);
        check("A0 config", 8'hfe, cfg[0]);
        check("B3 config", 8'h94, cfg[7]);
        reg_read(8'h03, 8'hfd, "reserved bit");
    endtask : t_config

    task automatic t_activity();
        logic [7:0] act [2] = '{8'h1e, 8'hc3};
        logic [7:0] stat [2] = '{8'he1, 8'h3c};
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_i);
            activity <= act[k];
            clks(4);
            check("squelch", ~act[k], squelch);
            reg_read(8'h00, stat[k], "activity status");
        end
    endtask : t_activity

    task automatic t_level();
        reg_write(8'h0b, 8'h01);
        for (int k = 1; k >= 0; k--) begin
            @(posedge clk_i);
            lvl_pin <= k[0];
            clks(4);
            check("threshold code", 8'({1'b1, k[0]}), 8'(level));
        end
    endtask : t_level

    task automatic t_foreign();
        i_host.start();
        send({3'h7, ~STRAP, 1'b0}, 1'b1);
        i_host.stop();
        i_host.start();
        send({3'h6, STRAP, 1'b1}, 1'b1);
        i_host.stop();
    endtask : t_foreign

    task automatic t_detect();
        @(posedge clk_i);
        far_end <= 8'h0f;
        clks(60);
        reg_read(8'h01, 8'hf0, "far end found");
        check("out terms", 8'h0f, out_term);
        check("in terms", 8'h05, in_term);
        check("probe", 8'h01, 8'(probe));
        @(posedge clk_i);
        far_end <= 8'h00;
        reg_read(8'h01, 8'hf0, "far end sticky");
        @(posedge clk_i);
        absent_n <= 1'b1;
        clks(6);
        check("cable out power", 8'h01, 8'(low_power));
        check("cable out terms", 8'h00, in_term | out_term);
        absent_n <= 1'b0;
        reg_read(8'h01, 8'h00, "restart clears");
        @(posedge clk_i);
        far_end <= 8'h30;
        clks(60);
        reg_read(8'h01, 8'h03, "far end bank B");
        @(posedge clk_i);
        far_end <= 8'h00;
        rst_n <= 1'b0;
        clks(8);
        rst_n <= 1'b1;
        reg_read(8'h01, 8'h00, "reset restart");
        reg_read(8'h02, 8'h00, "reset power down");
    endtask : t_detect

    task automatic t_pins();
        logic [5:0] pins [5] = '{6'h00, 6'h11, 6'h24, 6'h06, 6'h19};
        logic [3:0] code [5] = '{4'h0, 4'h5, 4'ha, 4'hd, 4'h7};
        @(posedge clk_i);
        src <= rdc_pkg::RDC_LVL_LOW;
        for (int k = 0; k < 5; k++) begin
            eq_a <= rdc_pkg::rdc_eq_pins_t'(pins[k]);
            eq_b <= rdc_pkg::rdc_eq_pins_t'(pins[4 - k]);
            gain_a <= k[1:0];
            gain_b <= ~k[1:0];
            swing <= k[0];
            lvl_pin <= k[1];
            clks(4);
            check("bank A", 8'({code[k], k[1:0], k[0]}), 8'(cfg[0][7:1]));
            check("bank B", 8'({code[4 - k], ~k[1:0], k[0]}), 8'(cfg[4][7:1]));
            check("pin threshold", 8'({1'b0, k[1]}), 8'(level));
        end
    endtask : t_pins

    task automatic t_eeprom();
        @(posedge clk_i);
        src <= rdc_pkg::RDC_PIN_FLOAT_LEVEL;
        clks(4);
        check("load before", 8'h00, 8'(load_status));
        for (int k = 1; k >= 0; k--) begin
            ok <= k[0];
            done <= 1'b1;
            clks(4);
            done <= 1'b0;
            clks(4);
            check("load status", 8'(k[0]), 8'(load_status));
        end
    endtask : t_eeprom

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    initial begin
        clks(2);
        srst_i <= 1'b0;
        clks(10);
        t_reset();
        t_power_down();
        t_config();
        t_activity();
        t_level();
        t_foreign();
        t_detect();
        t_pins();
        t_eeprom();
        end_of_test();
    end

    initial begin
        #900us;
        miscompares++;
        $display("MISMATCH run time expected finish seen timeout");
        end_of_test();
    end
endmodule : tb_top

// *** hw/rdc_top.sv ***
`timescale 1ns/100ps
module rdc_top #(
    parameter int unsigned DET_WINDOW_CYC = rdc_pkg::RDC_DET_WINDOW_CYC
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [3:0] addr_strap_i,
    input wire logic reg_reset_n_i,
    input wire logic cable_absent_n_i,
    input wire rdc_pkg::rdc_lvl_t config_source_select_i,
    input wire rdc_pkg::rdc_eq_pins_t bank_a_eq_pins_i,
    input wire rdc_pkg::rdc_eq_pins_t bank_b_eq_pins_i,
    input wire logic [1:0] bank_a_gain_pins_i,
    input wire logic [1:0] bank_b_gain_pins_i,
    input wire logic swing_select_i,
    input wire logic detect_level_pin_i,
    input wire logic [7:0] activity_i,
    input wire logic [7:0] far_end_detect_i,
    input wire logic eeprom_load_done_i,
    input wire logic eeprom_load_ok_i,
    output rdc_pkg::rdc_ch_cfg_t [7:0] ch_cfg_o,
    output logic [1:0] detect_level_o,
    output logic low_power_o,
    output logic [7:0] in_term_50_o,
    output logic [7:0] out_term_50_o,
    output logic det_probe_o,
    output logic [7:0] squelch_o,
    output logic load_status_o
);
    localparam int unsigned WIN_W = $clog2(DET_WINDOW_CYC);

    // ==========================================================
    // Pin synchronisers.
    rdc_pkg::rdc_pins_t pins_raw;
    rdc_pkg::rdc_pins_t pins_s1_q;
    rdc_pkg::rdc_pins_t pins_q;

    assign pins_raw = {scl_i, sda_i, addr_strap_i, reg_reset_n_i, cable_absent_n_i, config_source_select_i,
                       bank_a_eq_pins_i, bank_b_eq_pins_i, bank_a_gain_pins_i, bank_b_gain_pins_i,
                       swing_select_i, detect_level_pin_i, activity_i, far_end_detect_i,
                       eeprom_load_done_i, eeprom_load_ok_i};

    always_ff @(posedge clk_i) begin
        pins_s1_q <= pins_raw;
        pins_q <= pins_s1_q;
    end

    // ==========================================================
    // Bus start and stop detection, link reset.
    logic sda_prev_q;
    logic link_idle_q;
    logic [2:0] link_cnt_q;
    logic link_rst_q;
    logic link_por_q;
    logic bus_start;
    logic bus_stop;
    logic [3:0] strap_q;

    assign bus_start = pins_q.scl & sda_prev_q & ~pins_q.sda;
    assign bus_stop = pins_q.scl & ~sda_prev_q & pins_q.sda;
    always_ff @(posedge clk_i) begin
        sda_prev_q <= srst_i ? 1'b1 : pins_q.sda;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            link_idle_q <= 1'b1;
            link_cnt_q <= 3'h0;
            link_rst_q <= 1'b1;
        end else begin
            if (bus_start) begin
                link_idle_q <= 1'b0;
                link_cnt_q <= rdc_pkg::RDC_LINK_RST_CYC;
            end else if (bus_stop) begin
                link_idle_q <= 1'b1;
            end else if (link_cnt_q != 3'h0) begin
                link_cnt_q <= link_cnt_q - 3'h1;
            end
            link_rst_q <= bus_start | bus_stop | (link_idle_q & ~bus_start) | (link_cnt_q != 3'h0);
        end
    end

    always_ff @(posedge clk_i) begin
        link_por_q <= srst_i;
        strap_q <= srst_i ? 4'h0 : pins_q.addr_strap;
    end

    // ==========================================================
    // Link side: bit engine on the bus clock.
    rdc_pkg::rdc_link_st_t st_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic oe_q;
    logic [7:0] ptr_q;
    logic [7:0] wr_ptr_q;
    logic [7:0] wr_data_q;
    logic wr_tgl_q;
    logic rd_tgl_q;
    logic [7:0] rd_byte_q;
    logic addr_hit;
    logic ack_bit;
    assign addr_hit = (shift_q[7:1] == {rdc_pkg::RDC_DEV_ADDR_HI, strap_q});
    assign ack_bit = (bit_q == rdc_pkg::RDC_BIT_ACK);
    always_ff @(posedge scl_i or posedge link_rst_q) begin
        if (link_rst_q) begin
            st_q <= rdc_pkg::RDC_LK_ADDR;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
        end else if (!ack_bit) begin
            shift_q <= {shift_q[6:0], sda_i};
            bit_q <= bit_q + 4'h1;
        end else begin
            bit_q <= 4'h0;
            unique case (st_q)
                rdc_pkg::RDC_LK_ADDR: begin
                    if (!addr_hit) begin
                        st_q <= rdc_pkg::RDC_LK_IGNORE;
                    end else if (shift_q[0]) begin
                        st_q <= rdc_pkg::RDC_LK_RDATA;
                    end else begin
                        st_q <= rdc_pkg::RDC_LK_PTR;
                    end
                end
                rdc_pkg::RDC_LK_PTR: st_q <= rdc_pkg::RDC_LK_WDATA;
                rdc_pkg::RDC_LK_WDATA: st_q <= rdc_pkg::RDC_LK_WDATA;
                rdc_pkg::RDC_LK_RDATA: begin
                    if (sda_i) begin
                        st_q <= rdc_pkg::RDC_LK_IGNORE;
                    end
                end
                rdc_pkg::RDC_LK_IGNORE: st_q <= rdc_pkg::RDC_LK_IGNORE;
                default: st_q <= rdc_pkg::RDC_LK_IGNORE;
            endcase
        end
    end

    // Pointer and transfer events survive frame boundaries.
    always_ff @(posedge scl_i or posedge link_por_q) begin
        if (link_por_q) begin
            ptr_q <= 8'h00;
            wr_ptr_q <= 8'h00;
            wr_data_q <= 8'h00;
            wr_tgl_q <= 1'b0;
            rd_tgl_q <= 1'b0;
        end else if (ack_bit) begin
            if (st_q == rdc_pkg::RDC_LK_ADDR && addr_hit && shift_q[0]) begin
                rd_tgl_q <= ~rd_tgl_q;
            end
            if (st_q == rdc_pkg::RDC_LK_PTR) begin
                ptr_q <= shift_q;
            end
            if (st_q == rdc_pkg::RDC_LK_WDATA) begin
                wr_ptr_q <= ptr_q;
                wr_data_q <= shift_q;
                wr_tgl_q <= ~wr_tgl_q;
                ptr_q <= ptr_q + 8'h01;
            end
            if (st_q == rdc_pkg::RDC_LK_RDATA && !sda_i) begin
                ptr_q <= ptr_q + 8'h01;
                rd_tgl_q <= ~rd_tgl_q;
            end
        end
    end

    // Data changes only while the bus clock is low.
    always_ff @(negedge scl_i or posedge link_rst_q) begin
        if (link_rst_q) begin
            oe_q <= 1'b0;
            tx_q <= 8'h00;
        end else if (ack_bit) begin
            oe_q <= (st_q == rdc_pkg::RDC_LK_ADDR && addr_hit) || (st_q == rdc_pkg::RDC_LK_PTR) ||
                    (st_q == rdc_pkg::RDC_LK_WDATA);
        end else if (st_q == rdc_pkg::RDC_LK_RDATA && bit_q == 4'h0) begin
            oe_q <= ~rd_byte_q[7];
            tx_q <= {rd_byte_q[6:0], 1'b0};
        end else if (st_q == rdc_pkg::RDC_LK_RDATA) begin
            oe_q <= ~tx_q[7];
            tx_q <= {tx_q[6:0], 1'b0};
        end else begin
            oe_q <= 1'b0;
        end
    end
    assign sda_o = 1'b0;
    assign sda_oe_o = oe_q;

    // ==========================================================
    // Event crossings from the link side.
    logic [2:0] wr_sync_q;
    logic [2:0] rd_sync_q;
    logic wr_evt;
    logic rd_evt;

    always_ff @(posedge clk_i) begin
        wr_sync_q <= srst_i ? 3'h0 : {wr_sync_q[1:0], wr_tgl_q};
        rd_sync_q <= srst_i ? 3'h0 : {rd_sync_q[1:0], rd_tgl_q};
    end

    assign wr_evt = wr_sync_q[2] ^ wr_sync_q[1];
    assign rd_evt = rd_sync_q[2] ^ rd_sync_q[1];

    // ==========================================================
    // Writable registers.
    localparam int unsigned RDC_NUM_CH_L = rdc_pkg::RDC_NUM_CH;
    logic [7:0] pd_q;
    logic [7:0] cfg_q [RDC_NUM_CH_L];
    logic level_bit_q;
    logic [2:0] wr_idx;
    logic wr_in_cfg;
    assign wr_idx = 3'(wr_ptr_q - rdc_pkg::RDC_REG_CFG_BASE);
    assign wr_in_cfg = (wr_ptr_q >= rdc_pkg::RDC_REG_CFG_BASE) && (wr_ptr_q <= rdc_pkg::RDC_REG_CFG_LAST);
    always_ff @(posedge clk_i) begin
        if (srst_i || !pins_q.reg_reset_n) begin
            pd_q <= rdc_pkg::RDC_REG_RESET;
            level_bit_q <= 1'b0;
            for (int i = 0; i < RDC_NUM_CH_L; i++) begin
                cfg_q[i] <= rdc_pkg::RDC_REG_RESET;
            end
        end else if (wr_evt) begin
            if (wr_ptr_q == rdc_pkg::RDC_REG_PWR_DOWN) begin
                pd_q <= wr_data_q;
            end else if (wr_in_cfg) begin
                cfg_q[wr_idx] <= wr_data_q & rdc_pkg::RDC_CFG_WR_MASK;
            end else if (wr_ptr_q == rdc_pkg::RDC_REG_DET_LEVEL) begin
                level_bit_q <= wr_data_q[rdc_pkg::RDC_DET_LEVEL_BIT_POS];
            end
        end
    end

    // ==========================================================
    // Termination detection poller.
    rdc_pkg::rdc_det_st_t det_st_q;
    logic [WIN_W-1:0] win_cnt_q;
    logic [7:0] found_q;
    logic det_hold;
    assign det_hold = pins_q.cable_absent_n | ~pins_q.reg_reset_n;
    always_ff @(posedge clk_i) begin
        if (srst_i || det_hold) begin
            det_st_q <= rdc_pkg::RDC_DET_HOLD;
            win_cnt_q <= '0;
            found_q <= 8'h00;
        end else begin
            det_st_q <= rdc_pkg::RDC_DET_POLL;
            if (win_cnt_q == WIN_W'(DET_WINDOW_CYC - 1)) begin
                win_cnt_q <= '0;
                found_q <= found_q | pins_q.far_end;
            end else begin
                win_cnt_q <= win_cnt_q + WIN_W'(1);
            end
        end
    end

    // ==========================================================
    // Read data fetch for the link side.
    function automatic logic [7:0] ch_order(input logic [7:0] v);
        return {v[3:0], v[7:4]};
    endfunction : ch_order

    logic [7:0] rd_mux;
    logic [2:0] rd_idx;

    assign rd_idx = 3'(ptr_q - rdc_pkg::RDC_REG_CFG_BASE);

    always_comb begin
        rd_mux = 8'h00;
        if (ptr_q == rdc_pkg::RDC_REG_ACT_STAT) begin
            rd_mux = ch_order(pins_q.activity);
        end else if (ptr_q == rdc_pkg::RDC_REG_TERM_STAT) begin
            rd_mux = ch_order(found_q);
        end else if (ptr_q == rdc_pkg::RDC_REG_PWR_DOWN) begin
            rd_mux = pd_q;
        end else if (ptr_q >= rdc_pkg::RDC_REG_CFG_BASE && ptr_q <= rdc_pkg::RDC_REG_CFG_LAST) begin
            rd_mux = cfg_q[rd_idx];
        end else if (ptr_q == rdc_pkg::RDC_REG_DET_LEVEL) begin
            rd_mux = {7'h00, level_bit_q};
        end
    end
    always_ff @(posedge clk_i) begin
        rd_byte_q <= srst_i ? 8'h00 : (rd_evt ? rd_mux : rd_byte_q);
    end

    // ==========================================================
    // Configuration decode and control outputs.
    function automatic logic [3:0] eq_decode(input rdc_pkg::rdc_eq_pins_t p);
        logic b2, b1, b0;
        b2 = (p.eq2 == rdc_pkg::RDC_LVL_HIGH);
        b1 = (p.eq1 != rdc_pkg::RDC_LVL_LOW);
        b0 = (p.eq0 == rdc_pkg::RDC_LVL_HIGH);
        if (p.eq2 == rdc_pkg::RDC_PIN_FLOAT_LEVEL) begin
            return {2'b10, b1, b0};
        end else if (p.eq0 == rdc_pkg::RDC_PIN_FLOAT_LEVEL) begin
            return {2'b11, b2, b1};
        end
        return {1'b0, b2, b1, b0};
    endfunction : eq_decode

    rdc_pkg::rdc_ch_cfg_t [7:0] cfg_out_q;
    logic [1:0] level_q;
    logic pin_mode;
    logic absent;

    assign pin_mode = (pins_q.source == rdc_pkg::RDC_LVL_LOW);
    assign absent = pins_q.cable_absent_n;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cfg_out_q <= '0;
            level_q <= 2'h0;
        end else begin
            for (int c = 0; c < RDC_NUM_CH_L; c++) begin
                if (pin_mode) begin
                    cfg_out_q[c].eq_code <= eq_decode(c < 4 ? pins_q.eq_a : pins_q.eq_b);
                    cfg_out_q[c].gain_code <= (c < 4) ? pins_q.gain_a : pins_q.gain_b;
                    cfg_out_q[c].swing <= pins_q.swing_select;
                end else begin
                    cfg_out_q[c].eq_code <= cfg_q[c][rdc_pkg::RDC_CFG_EQ_CODE_MSB:rdc_pkg::RDC_CFG_EQ_LSB];
                    cfg_out_q[c].gain_code <= cfg_q[c][rdc_pkg::RDC_CFG_GAIN_CODE_MSB:rdc_pkg::RDC_CFG_GAIN_LSB];
                    cfg_out_q[c].swing <= cfg_q[c][rdc_pkg::RDC_CFG_SWING_BIT];
                end
                cfg_out_q[c].power_down <= absent | pd_q[3'(c) ^ 3'h4];
            end
            level_q <= pin_mode ? {1'b0, pins_q.detect_level_pin} : {level_bit_q, pins_q.detect_level_pin};
        end
    end

    logic low_power_q;
    logic [7:0] in_term_q;
    logic [7:0] out_term_q;
    logic [7:0] squelch_q;
    logic load_ok_q;
    logic [7:0] pd_ch;

    assign pd_ch = ch_order(pd_q);

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            low_power_q <= 1'b1;
            in_term_q <= 8'h00;
            out_term_q <= 8'h00;
            squelch_q <= 8'hff;
        end else begin
            low_power_q <= absent;
            out_term_q <= found_q & ~{8{absent}};
            in_term_q <= found_q & ~pd_ch & ~{8{absent}};
            squelch_q <= ~pins_q.activity;
        end
    end
    always_ff @(posedge clk_i) begin
        load_ok_q <= srst_i ? 1'b0 : (pins_q.load_done ? pins_q.load_ok : load_ok_q);
    end

    assign ch_cfg_o = cfg_out_q;
    assign detect_level_o = level_q;
    assign low_power_o = low_power_q;
    assign in_term_50_o = in_term_q;
    assign out_term_50_o = out_term_q;
    assign det_probe_o = (det_st_q == rdc_pkg::RDC_DET_POLL) && (found_q != 8'hff);
    assign squelch_o = squelch_q;
    assign load_status_o = load_ok_q;
endmodule : rdc_top

// *** inc/rdc_pkg.sv ***
package rdc_pkg;
    // Functional notes
    // - Cable absent high selects low power mode.
    // - Load status low on failure, high on success.
    // - Restart sets outputs high impedance, inputs 200K.
    // - Poll each channel in 40us windows until detected.
    // - Detection restarts only on cable or reset toggle.
    // - Squelch output while input activity is absent.
    // - Cable absent forces power down in every mode.
    // - Power-down byte, one bit per channel.
    // - Pin mode decodes three-level pins to 4-bit code.
    // - Two-bit flat gain code per bank.
    // - One swing bit shared by both banks.
    // - Threshold code is register bit over pin; pin mode puts zero over pin.
    // - Bus address is 111 plus four strap bits.
    // - Read-only activity status byte.
    // - Read-only far-end termination status byte.
    // - Three-level select picks pin, register or EEPROM; here the float level uses the registers, as high does.
    // - Register reset holds writable registers at default.
    // - Per-channel configuration byte: eq, gain, swing.

    // ==========================================================
    // Register map and fields.
    localparam int unsigned RDC_NUM_CH = 8;
    localparam logic [7:0] RDC_REG_ACT_STAT = 8'h00;
    localparam logic [7:0] RDC_REG_TERM_STAT = 8'h01;
    localparam logic [7:0] RDC_REG_PWR_DOWN = 8'h02;
    localparam logic [7:0] RDC_REG_CFG_BASE = 8'h03;
    localparam logic [7:0] RDC_REG_CFG_LAST = 8'h0a;
    localparam logic [7:0] RDC_REG_DET_LEVEL = 8'h0b;
    localparam logic [7:0] RDC_REG_RESET = 8'h00;
    localparam logic [7:0] RDC_CFG_WR_MASK = 8'hfd;
    localparam int unsigned RDC_CFG_EQ_LSB = 4;
    localparam int unsigned RDC_CFG_EQ_CODE_MSB = 7;
    localparam int unsigned RDC_CFG_GAIN_LSB = 2;
    localparam int unsigned RDC_CFG_GAIN_CODE_MSB = 3;
    localparam int unsigned RDC_CFG_SWING_BIT = 0;
    localparam int unsigned RDC_DET_LEVEL_BIT_POS = 0;
    localparam logic [2:0] RDC_DEV_ADDR_HI = 3'h7;
    localparam logic [3:0] RDC_BIT_ACK = 4'h8;

    // ==========================================================
    // Timing.
    localparam int unsigned RDC_CLK_FREQ_MHZ = 100;
    localparam int unsigned RDC_DET_WINDOW_US = 40;
    localparam int unsigned RDC_DET_WINDOW_CYC = RDC_DET_WINDOW_US * RDC_CLK_FREQ_MHZ;
    localparam logic [2:0] RDC_LINK_RST_CYC = 3'h4;

    // ==========================================================
    // Types.
    typedef enum logic [1:0] {RDC_LVL_LOW, RDC_LVL_HIGH, RDC_PIN_FLOAT_LEVEL} rdc_lvl_t;
    typedef struct packed {rdc_lvl_t eq2; rdc_lvl_t eq1; rdc_lvl_t eq0;} rdc_eq_pins_t;
    typedef struct packed {logic [3:0] eq_code; logic [1:0] gain_code; logic swing; logic power_down;} rdc_ch_cfg_t;
    typedef struct packed {
        logic scl;
        logic sda;
        logic [3:0] addr_strap;
        logic reg_reset_n;
        logic cable_absent_n;
        rdc_lvl_t source;
        rdc_eq_pins_t eq_a;
        rdc_eq_pins_t eq_b;
        logic [1:0] gain_a;
        logic [1:0] gain_b;
        logic swing_select;
        logic detect_level_pin;
        logic [7:0] activity;
        logic [7:0] far_end;
        logic load_done;
        logic load_ok;
    } rdc_pins_t;
    typedef enum logic [2:0] {RDC_LK_ADDR, RDC_LK_PTR, RDC_LK_WDATA, RDC_LK_RDATA, RDC_LK_IGNORE} rdc_link_st_t;
    typedef enum logic {RDC_DET_HOLD, RDC_DET_POLL} rdc_det_st_t;
endpackage : rdc_pkg
